// >>> logic/mpp_port.sv
// Purpose: MII/RMII media port toward a PHY or, in DCE mode, a peer MAC
// Assumes: All link pins are asynchronous to clk_i and oversampled by it
// Notes: Link clocks are found by edge detection, not used as clocks
//
// Chosen here: the register addresses and the Wishbone interface to the registers.
`timescale 1ns/1ps
`default_nettype none

module mpp_fifo #(
    parameter int WIDTH = 10,
    parameter int DEPTH = 8
) (
    // Clock and reset
    input wire logic clk_i,
    input wire logic rst_i,
    // Fill side
    input wire logic in_valid_i,
    output logic in_ready_o,
    input wire logic [WIDTH-1:0] in_data_i,
    // Drain side
    output logic out_valid_o,
    input wire logic out_ready_i,
    output logic [WIDTH-1:0] out_data_o
);
    localparam int AW = $clog2(DEPTH);
    logic [WIDTH-1:0] mem_q [DEPTH];
    logic [AW-1:0] wr_q, rd_q;
    logic [AW:0] cnt_q;
    wire push = in_valid_i && in_ready_o;
    wire pop = out_valid_o && out_ready_i;
    assign in_ready_o = (cnt_q != (AW+1)'(DEPTH));
    assign out_valid_o = (cnt_q != '0);
    assign out_data_o = mem_q[rd_q];
    always_ff @(posedge clk_i)
    begin
        if (push)
            mem_q[wr_q] <= in_data_i;
    end
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            wr_q <= '0;
            rd_q <= '0;
            cnt_q <= '0;
        end
        else
        begin
            if (push)
                wr_q <= wr_q + 1'b1;
            if (pop)
                rd_q <= rd_q + 1'b1;
            cnt_q <= cnt_q + {{AW{1'b0}}, push} - {{AW{1'b0}}, pop};
        end
    end
endmodule // mpp_fifo

module mpp_port (
    // Clock and reset
    input wire logic clk_i,
    input wire logic rst_i,
    // Wishbone slave
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [3:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    output logic [31:0] wb_dat_o,
    output logic wb_ack_o,
    // Straps
    input wire logic link_role_select_i,
    input wire logic reduced_iface_select_i,
    // Link clocks; MII clocks are two-way
    input wire logic ref_clk_i,
    input wire logic rx_clk_i,
    output logic rx_clk_o,
    output logic rx_clk_oe_o,
    input wire logic tx_clk_i,
    output logic tx_clk_o,
    output logic tx_clk_oe_o,
    // Link receive
    input wire logic [3:0] rxd_i,
    input wire logic rx_dv_i,
    input wire logic rx_carrier_sense_i,
    input wire logic rx_err_i,
    input wire logic collision_in_i,
    // Link transmit
    output logic [3:0] txd_o,
    output logic tx_en_o,
    // Receive stream
    output logic rx_valid_o,
    input wire logic rx_ready_i,
    output logic [7:0] rx_data_o,
    output logic rx_end_o,
    output logic rx_err_o,
    // Transmit stream
    input wire logic tx_valid_i,
    output logic tx_ready_o,
    input wire logic [7:0] tx_data_i,
    input wire logic tx_last_i
);
    // Shift a piece in at the top, two bits for RMII, four for MII
    function automatic logic [7:0] shift_in(input logic [7:0] sh, input logic [3:0] d,
                                            input logic rmii);
        shift_in = rmii ? {d[1:0], sh[7:2]} : {d, sh[7:4]};
    endfunction

    // Three-stage synchroniser; a change counts once stages two and three agree
    logic [mpp_pkg::SYN_W-1:0] s1_q, s2_q, s3_q, flt_q;
    wire [mpp_pkg::SYN_W-1:0] raw = {1'b0, reduced_iface_select_i, link_role_select_i,
        collision_in_i, rx_err_i, rx_carrier_sense_i, rx_dv_i, rxd_i, ref_clk_i,
        tx_clk_i, rx_clk_i};
    wire [mpp_pkg::SYN_W-1:0] flt_d = (s2_q & s3_q) | (flt_q & (s2_q ^ s3_q));
    wire [mpp_pkg::SYN_W-1:0] rise = flt_d & ~flt_q;
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            s1_q <= '0;
            s2_q <= '0;
            s3_q <= '0;
            flt_q <= '0;
        end
        else
        begin
            s1_q <= raw;
            s2_q <= s1_q;
            s3_q <= s2_q;
            flt_q <= flt_d;
        end
    end

    // Mode decode
    logic speed100_q, fulldup_q;
    wire rmii = flt_q[mpp_pkg::SYN_RMII];
    wire dce = flt_q[mpp_pkg::SYN_ROLE] && !rmii;
    wire [3:0] rxd_now = flt_d[mpp_pkg::SYN_RXD +: 4];
    wire col_act = flt_q[mpp_pkg::SYN_COL] && !fulldup_q;

    // Reference divider: every rising edge at 100 Mbit/s, one in ten at 10
    logic [3:0] div_q;
    wire ref_rise = rise[mpp_pkg::SYN_REFCLK];
    wire ref_tick = ref_rise && (speed100_q || div_q == 4'h0);
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
            div_q <= 4'h0;
        else if (ref_rise)
            div_q <= (div_q == mpp_pkg::TEN_DIV - 4'h1) ? 4'h0 : div_q + 4'h1;
    end

    // DCE clock: 50 MHz reference halved to 25 MHz, or divided by 20 to 2.5 MHz
    logic mii_clk_q;
    wire gen_rise = ref_tick && !mii_clk_q;
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
            mii_clk_q <= 1'b0;
        else if (ref_tick)
            mii_clk_q <= !mii_clk_q;
    end
    assign rx_clk_o = mii_clk_q;
    assign tx_clk_o = mii_clk_q;
    assign rx_clk_oe_o = dce;
    assign tx_clk_oe_o = dce;

    // Sample events for each direction
    wire rx_evt = rmii ? ref_tick : (dce ? gen_rise : rise[mpp_pkg::SYN_RXCLK]);
    wire tx_evt = rmii ? ref_tick : (dce ? gen_rise : rise[mpp_pkg::SYN_TXCLK]);

    // Receive assembly
    wire qual = rmii ? flt_d[mpp_pkg::SYN_CRS] : flt_d[mpp_pkg::SYN_DV];
    logic [7:0] rsh_q;
    logic [1:0] rcnt_q;
    logic rframe_q, rerr_q, push_q, ovr_q;
    logic [mpp_pkg::RXW_W-1:0] pword_q;
    wire fifo_in_ready;
    wire [7:0] rsh_d = shift_in(rsh_q, rxd_now, rmii);
    wire rbyte_done = (rcnt_q == (rmii ? 2'h3 : 2'h1));
    wire rerr_now = qual && flt_d[mpp_pkg::SYN_ERR];
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            rsh_q <= 8'h00;
            rcnt_q <= 2'h0;
            rframe_q <= 1'b0;
            rerr_q <= 1'b0;
            push_q <= 1'b0;
            pword_q <= '0;
        end
        else
        begin
            push_q <= 1'b0;
            if (push_q && !fifo_in_ready && rframe_q)
                rerr_q <= 1'b1;
            if (rx_evt && qual)
            begin
                rsh_q <= rsh_d;
                rframe_q <= 1'b1;
                rcnt_q <= rbyte_done ? 2'h0 : rcnt_q + 2'h1;
                if (rerr_now)
                    rerr_q <= 1'b1;
                if (rbyte_done)
                begin
                    push_q <= 1'b1;
                    pword_q <= {2'b00, rsh_d};
                end
            end
            else if (rx_evt && rframe_q)
            begin
                push_q <= 1'b1;
                pword_q <= {1'b1, rerr_q, 8'h00};
                rframe_q <= 1'b0;
                rerr_q <= 1'b0;
                rcnt_q <= 2'h0;
            end
        end
    end

    // Link cannot be stalled, so a full FIFO loses the byte and marks the frame
    wire [mpp_pkg::RXW_W-1:0] fifo_out;
    mpp_fifo #(
        .WIDTH(mpp_pkg::RXW_W),
        .DEPTH(mpp_pkg::FIFO_DEPTH)
    ) u_rx_fifo (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .in_valid_i(push_q),
        .in_ready_o(fifo_in_ready),
        .in_data_i(pword_q),
        .out_valid_o(rx_valid_o),
        .out_ready_i(rx_ready_i),
        .out_data_o(fifo_out)
    );
    assign rx_data_o = fifo_out[7:0];
    assign rx_end_o = fifo_out[mpp_pkg::RXW_END];
    assign rx_err_o = fifo_out[mpp_pkg::RXW_ERR];

    // Transmit: one byte of staging, then pieces on each transmit event
    mpp_pkg::mpp_tx_state_t st_q;
    logic [7:0] buf_q, tsh_q;
    logic buf_full_q, buf_last_q, tlast_q, tx_en_q, col_q;
    logic [1:0] tcnt_q;
    logic [3:0] txd_q;
    assign tx_ready_o = !buf_full_q;
    wire tx_take = tx_valid_i && tx_ready_o;
    wire [1:0] pieces_m1 = rmii ? 2'h3 : 2'h1;
    wire [3:0] first_pc = rmii ? {2'b00, buf_q[1:0]} : buf_q[3:0];
    wire [3:0] next_pc = rmii ? {2'b00, tsh_q[3:2]} : tsh_q[7:4];
    wire [7:0] tsh_next = rmii ? {2'b00, tsh_q[7:2]} : {4'h0, tsh_q[7:4]};
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            st_q <= mpp_pkg::TX_IDLE;
            buf_q <= 8'h00;
            buf_full_q <= 1'b0;
            buf_last_q <= 1'b0;
            tsh_q <= 8'h00;
            tlast_q <= 1'b0;
            tcnt_q <= 2'h0;
            tx_en_q <= 1'b0;
            txd_q <= 4'h0;
        end
        else
        begin
            if (tx_take)
            begin
                buf_q <= tx_data_i;
                buf_last_q <= tx_last_i;
                buf_full_q <= 1'b1;
            end
            case (st_q)
                mpp_pkg::TX_IDLE:
                    if (tx_evt && buf_full_q)
                    begin
                        tsh_q <= buf_q;
                        tlast_q <= buf_last_q;
                        buf_full_q <= 1'b0;
                        tcnt_q <= pieces_m1;
                        txd_q <= first_pc;
                        tx_en_q <= 1'b1;
                        st_q <= mpp_pkg::TX_SEND;
                    end
                mpp_pkg::TX_SEND:
                    if (col_act)
                    begin
                        tx_en_q <= 1'b0;
                        st_q <= tlast_q ? mpp_pkg::TX_GAP : mpp_pkg::TX_DROP;
                    end
                    else if (tx_evt && tcnt_q != 2'h0)
                    begin
                        txd_q <= next_pc;
                        tsh_q <= tsh_next;
                        tcnt_q <= tcnt_q - 2'h1;
                    end
                    else if (tx_evt && !tlast_q && buf_full_q)
                    begin
                        tsh_q <= buf_q;
                        tlast_q <= buf_last_q;
                        buf_full_q <= 1'b0;
                        tcnt_q <= pieces_m1;
                        txd_q <= first_pc;
                    end
                    else if (tx_evt)
                    begin
                        // Last piece done, or underrun aborts the frame
                        tx_en_q <= 1'b0;
                        txd_q <= 4'h0;
                        st_q <= tlast_q ? mpp_pkg::TX_GAP : mpp_pkg::TX_DROP;
                    end
                mpp_pkg::TX_GAP:
                    if (tx_evt)
                        st_q <= mpp_pkg::TX_IDLE;
                mpp_pkg::TX_DROP:
                    if (buf_full_q)
                    begin
                        // Discard the rest of an aborted frame
                        buf_full_q <= 1'b0;
                        if (buf_last_q)
                            st_q <= mpp_pkg::TX_GAP;
                    end
                    else
                        st_q <= st_q;
                default:
                    st_q <= mpp_pkg::TX_IDLE;
            endcase
        end
    end
    // Drop state also accepts bytes so the source can drain
    assign txd_o = txd_q;
    assign tx_en_o = tx_en_q;

    // Registers
    wire wb_req = wb_cyc_i && wb_stb_i && !wb_ack_o;
    wire sel_ctrl = (wb_adr_i == mpp_pkg::CTRL_OFS);
    wire sel_stat = (wb_adr_i == mpp_pkg::STAT_OFS);
    wire col_clr = wb_req && wb_we_i && sel_stat && wb_sel_i[0] && wb_dat_i[mpp_pkg::STAT_COL_BIT];
    wire ovr_clr = wb_req && wb_we_i && sel_stat && wb_sel_i[0] && wb_dat_i[mpp_pkg::STAT_OVR_BIT];
    wire [31:0] stat_word = {27'h0, st_q != mpp_pkg::TX_IDLE, ovr_q, col_q, dce, rmii};
    wire [31:0] ctrl_word = {30'h0, fulldup_q, speed100_q};
    wire [31:0] rd_word = sel_ctrl ? ctrl_word : (sel_stat ? stat_word : 32'h0);
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            wb_ack_o <= 1'b0;
            wb_dat_o <= 32'h0;
            speed100_q <= mpp_pkg::CTRL_SPEED100_RST;
            fulldup_q <= mpp_pkg::CTRL_FULLDUP_RST;
            col_q <= 1'b0;
            ovr_q <= 1'b0;
        end
        else
        begin
            wb_ack_o <= wb_req;
            wb_dat_o <= wb_req ? rd_word : 32'h0;
            if (wb_req && wb_we_i && sel_ctrl && wb_sel_i[0])
            begin
                speed100_q <= wb_dat_i[mpp_pkg::CTRL_SPEED100_BIT];
                fulldup_q <= wb_dat_i[mpp_pkg::CTRL_FULLDUP_BIT];
            end
            // Set wins over a clear in the same cycle
            col_q <= (col_q && !col_clr) || (col_act && st_q == mpp_pkg::TX_SEND);
            ovr_q <= (ovr_q && !ovr_clr) || (push_q && !fifo_in_ready);
        end
    end

    // Checks
    chk_col_fulldup: assert property (@(posedge clk_i) disable iff (rst_i)
        fulldup_q && st_q == mpp_pkg::TX_SEND && !tx_evt |=> st_q != mpp_pkg::TX_DROP)
        else $error("Collision acted on in full duplex");
    chk_col_abort: assert property (@(posedge clk_i) disable iff (rst_i)
        col_act && st_q == mpp_pkg::TX_SEND |=> !tx_en_o)
        else $error("Half duplex collision did not drop transmit enable");
    chk_dce_oe: assert property (@(posedge clk_i) disable iff (rst_i)
        rx_clk_oe_o |-> !flt_q[mpp_pkg::SYN_RMII] && flt_q[mpp_pkg::SYN_ROLE])
        else $error("Clock driven outside DCE MII mode");
    chk_ten_div: assert property (@(posedge clk_i) disable iff (rst_i)
        ref_tick && !speed100_q |-> div_q == 4'h0)
        else $error("10 Mbit/s sample not one in ten");
    chk_gen_clk: assert property (@(posedge clk_i) disable iff (rst_i)
        $changed(mii_clk_q) |-> $past(ref_tick))
        else $error("Generated clock moved without a reference tick");
    chk_rx_qual: assert property (@(posedge clk_i) disable iff (rst_i)
        rx_evt && !qual && !rframe_q |=> !push_q)
        else $error("Byte pushed without data valid");
    chk_rx_err: assert property (@(posedge clk_i) disable iff (rst_i)
        rx_evt && rerr_now |=> rerr_q)
        else $error("Receive error not recorded");
    chk_tx_gap: assert property (@(posedge clk_i) disable iff (rst_i)
        st_q == mpp_pkg::TX_GAP |-> !tx_en_o)
        else $error("Transmit enable high between frames");
    chk_tx_start: assert property (@(posedge clk_i) disable iff (rst_i)
        $rose(tx_en_o) |-> $past(tx_evt))
        else $error("Transmit enable rose off a clock edge");
    cov_frame_rx: cover property (@(posedge clk_i) push_q && pword_q[mpp_pkg::RXW_END]);
    cov_frame_tx: cover property (@(posedge clk_i) $fell(tx_en_o) && st_q == mpp_pkg::TX_GAP);
    cov_collide: cover property (@(posedge clk_i) col_act && st_q == mpp_pkg::TX_SEND);
    cov_overrun: cover property (@(posedge clk_i) push_q && !fifo_in_ready);
endmodule // mpp_port
`default_nettype wire

// >>> include/mpp_pkg.sv
// Purpose: Constants for the MII/RMII media port
// Assumes: 32-bit classic Wishbone register bus
// Notes: Register offsets are byte addresses
`default_nettype none
package mpp_pkg;
    // Register map
    localparam logic [3:0] CTRL_OFS = 4'h0;
    localparam logic [3:0] STAT_OFS = 4'h4;
    // Control fields and reset values
    localparam int CTRL_SPEED100_BIT = 0;
    localparam int CTRL_FULLDUP_BIT = 1;
    localparam logic CTRL_SPEED100_RST = 1'h1;
    localparam logic CTRL_FULLDUP_RST = 1'h1;
    // Status fields
    localparam int STAT_RMII_BIT = 0;
    localparam int STAT_DCE_BIT = 1;
    localparam int STAT_COL_BIT = 2;
    localparam int STAT_OVR_BIT = 3;
    localparam int STAT_TXACT_BIT = 4;
    // Synchroniser bus layout
    localparam int SYN_W = 14;
    localparam int SYN_RXCLK = 0;
    localparam int SYN_TXCLK = 1;
    localparam int SYN_REFCLK = 2;
    localparam int SYN_RXD = 3;
    localparam int SYN_DV = 7;
    localparam int SYN_CRS = 8;
    localparam int SYN_ERR = 9;
    localparam int SYN_COL = 10;
    localparam int SYN_ROLE = 11;
    localparam int SYN_RMII = 12;
    localparam int SYN_SPARE = 13;
    // Reference periods per 10 Mbit/s sample
    localparam logic [3:0] TEN_DIV = 4'ha;
    // Receive FIFO word: end flag, error flag, byte
    localparam int RXW_W = 10;
    localparam int RXW_END = 9;
    localparam int RXW_ERR = 8;
    localparam int FIFO_DEPTH = 8;
    typedef enum logic [1:0] {TX_IDLE, TX_SEND, TX_GAP, TX_DROP} mpp_tx_state_t;
endpackage
`default_nettype wire

// >>> verif/mpp_phy_model.sv
// Purpose: Behavioural MII PHY facing the media port in DTE mode
// Assumes: Both PHY clocks run free with a 160 ns period
// Notes: Idle receive data toggles so a stale value never passes as a sample
`timescale 1ns/1ps
`default_nettype none
module mpp_phy_model (
    // PHY clocks
    output logic rx_clk_o,
    output logic tx_clk_o,
    // Receive toward the port
    output logic [3:0] rxd_o,
    output logic rx_dv_o,
    output logic rx_carrier_sense_o,
    output logic rx_err_o,
    // Transmit from the port
    input wire logic [3:0] txd_i,
    input wire logic tx_en_i
);
    logic [7:0] frame_q [0:15];
    logic [7:0] tx_q [$];
    logic [3:0] low_q = 4'h0;
    logic half_q = 1'b0;
    logic busy_q = 1'b0;
    initial
    begin
        {rxd_o, rx_dv_o, rx_carrier_sense_o, rx_err_o} = 7'h00;
        rx_clk_o = 1'b0;
        #37;
        forever #80 rx_clk_o = ~rx_clk_o;
    end
    initial
    begin
        tx_clk_o = 1'b0;
        #53;
        forever #80 tx_clk_o = ~tx_clk_o;
    end
    always @(negedge rx_clk_o)
    begin
        if (!busy_q)
        begin
            rxd_o = ~rxd_o;
        end
    end
    task automatic send_frame(input int n, input int err_at, input logic idle_err);
        busy_q = 1'b1;
        for (int i = 0; i < 2 * n; i++)
        begin
            @(negedge rx_clk_o);
            rx_dv_o = 1'b1;
            rx_carrier_sense_o = 1'b1;
            rxd_o = i[0] ? frame_q[i / 2][7:4] : frame_q[i / 2][3:0];
            rx_err_o = (i / 2 == err_at);
        end
        @(negedge rx_clk_o);
        {rx_dv_o, rx_carrier_sense_o} = 2'h0;
        rxd_o = ~rxd_o;
        rx_err_o = idle_err;
        busy_q = 1'b0;
        repeat (4) @(negedge rx_clk_o);
        rx_err_o = 1'b0;
    endtask
    // Nibbles pair low first; an odd nibble at frame end is dropped
    always @(posedge tx_clk_o)
    begin
        if (tx_en_i !== 1'b1)
        begin
            half_q = 1'b0;
        end
        else if (half_q)
        begin
            tx_q.push_back({txd_i, low_q});
            half_q = 1'b0;
        end
        else
        begin
            low_q = txd_i;
            half_q = 1'b1;
        end
    end
endmodule // mpp_phy_model
`default_nettype wire

// >>> verif/mpp_port_test.sv
// Purpose: Self-checking bench for the MII/RMII media port
// Assumes: MII DTE with a behavioural PHY first, then DCE and RMII straps
// Notes: Link clocks are 160 ns, far slower than the 4 ns system clock
`timescale 1ns/1ps
`default_nettype none
module mpp_port_test;
    logic clk_i, rst_i, ref_clk, cyc, stb, we, role, rmii, col, rx_rdy, tx_vld, tx_lst, got;
    logic ack, rx_clk_o, rx_oe, tx_clk_o, tx_oe, tx_en, rx_valid, rx_end, rx_err, tx_ready;
    logic phy_rxc, phy_txc, dv, crs, rerr;
    logic [3:0] adr, txd, rxd;
    logic [31:0] wdat, rdat, q;
    logic [7:0] tx_dat, rx_data;
    logic [9:0] w;
    int err_count = 0;
    int checked = 0;
    int cycles = 0;
    int n;
    wire logic rx_clk_w = rx_oe ? rx_clk_o : phy_rxc;
    wire logic tx_clk_w = tx_oe ? tx_clk_o : phy_txc;
    mpp_port u_dut (
        .clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we),
        .wb_adr_i(adr), .wb_sel_i(4'hf), .wb_dat_i(wdat), .wb_dat_o(rdat), .wb_ack_o(ack),
        .link_role_select_i(role), .reduced_iface_select_i(rmii), .ref_clk_i(ref_clk),
        .rx_clk_i(rx_clk_w), .rx_clk_o(rx_clk_o), .rx_clk_oe_o(rx_oe),
        .tx_clk_i(tx_clk_w), .tx_clk_o(tx_clk_o), .tx_clk_oe_o(tx_oe),
        .rxd_i(rxd), .rx_dv_i(dv), .rx_carrier_sense_i(crs), .rx_err_i(rerr),
        .collision_in_i(col), .txd_o(txd), .tx_en_o(tx_en),
        .rx_valid_o(rx_valid), .rx_ready_i(rx_rdy), .rx_data_o(rx_data), .rx_end_o(rx_end),
        .rx_err_o(rx_err), .tx_valid_i(tx_vld), .tx_ready_o(tx_ready), .tx_data_i(tx_dat),
        .tx_last_i(tx_lst)
    );
    mpp_phy_model u_phy (
        .rx_clk_o(phy_rxc), .tx_clk_o(phy_txc), .rxd_o(rxd), .rx_dv_o(dv),
        .rx_carrier_sense_o(crs), .rx_err_o(rerr), .txd_i(txd), .tx_en_i(tx_en)
    );
    initial
    begin
        clk_i = 1'b0;
        forever #2 clk_i = ~clk_i;
    end
    initial
    begin
        ref_clk = 1'b0;
        #7;
        forever #80 ref_clk = ~ref_clk;
    end
    task automatic end_of_test();
        $display("comparisons %0d mismatches %0d", checked, err_count);
        if (err_count == 0 && checked > 0)
        begin
            $display("STATUS OK");
        end
        else
        begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask
    // A hung handshake must still reach the report
    always @(posedge clk_i)
    begin
        cycles++;
        if (cycles == 60000)
        begin
            err_count++;
            end_of_test();
        end
    end
    task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] seen);
        checked++;
        if (seen !== exp)
        begin
            err_count++;
            $display("BAD %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic wb(input logic w_i, input logic [3:0] a, input logic [31:0] d,
        output logic [31:0] r);
        int k;
        k = 0;
        {cyc, stb, we, adr, wdat} <= {1'b1, 1'b1, w_i, a, d};
        do
        begin
            @(posedge clk_i);
            k++;
        end
        while (ack !== 1'b1 && k < 64);
        if (ack !== 1'b1) chk("wb ack", 32'h1, 32'h0);
        r = rdat;
        {cyc, stb} <= 2'h0;
        @(posedge clk_i);
    endtask
    task automatic pop(output logic [9:0] wd, output logic ok);
        int k;
        k = 0;
        @(posedge clk_i);
        while (rx_valid !== 1'b1 && k < 2000)
        begin
            @(posedge clk_i);
            k++;
        end
        ok = (rx_valid === 1'b1);
        wd = {rx_end, rx_err, rx_data};
        if (ok)
        begin
            rx_rdy <= 1'b1;
            @(posedge clk_i);
            rx_rdy <= 1'b0;
        end
    endtask
    task automatic rx_frame(input int len, input int err_at, input logic idle_err,
        input logic exp_err);
        logic [9:0] wd;
        logic ok;
        for (int i = 0; i < len; i++) u_phy.frame_q[i] = 8'h5a + 8'(i * 37);
        u_phy.send_frame(len, err_at, idle_err);
        for (int i = 0; i <= len; i++)
        begin
            pop(wd, ok);
            chk("rx word", (i == len) ? {22'h0, 1'b1, exp_err, 8'h00} : {24'h0, u_phy.frame_q[i]},
                {22'h0, wd});
        end
    endtask
    // Waits on the busy flag, then two PHY clocks so the last nibble is captured
    task automatic tx_frame(input int len);
        logic [31:0] r;
        int k;
        for (int i = 0; i < len; i++)
        begin
            {tx_vld, tx_dat, tx_lst} <= {1'b1, 8'h3c + 8'(i * 29), i == len - 1};
            k = 0;
            do
            begin
                @(posedge clk_i);
                k++;
            end
            while (tx_ready !== 1'b1 && k < 4000);
            if (tx_ready !== 1'b1) chk("tx ready", 32'h1, 32'h0);
        end
        {tx_vld, tx_lst} <= 2'h0;
        k = 0;
        do
        begin
            wb(1'b0, mpp_pkg::STAT_OFS, 32'h0, r);
            k++;
        end
        while (r[mpp_pkg::STAT_TXACT_BIT] !== 1'b0 && k < 400);
        if (r[mpp_pkg::STAT_TXACT_BIT] !== 1'b0) chk("tx idle", 32'h0, 32'h1);
        repeat (2) @(posedge phy_txc);
        @(posedge clk_i);
    endtask
    task automatic period(output int p);
        for (int i = 0; i < 3; i++)
        begin
            p = 0;
            while (rx_clk_o !== 1'b1)
            begin
                @(posedge clk_i);
                p++;
            end
            while (rx_clk_o !== 1'b0)
            begin
                @(posedge clk_i);
                p++;
            end
        end
    endtask
    initial
    begin
        {rst_i, cyc, stb, we, role, rmii, col, rx_rdy, tx_vld, tx_lst} = 10'h200;
        {adr, wdat, tx_dat} = 44'h0;
        repeat (16) @(posedge clk_i);
        rst_i <= 1'b0;
        repeat (6) @(posedge clk_i);
        wb(1'b0, mpp_pkg::CTRL_OFS, 32'h0, q);
        chk("ctrl reset", 32'h3, q);
        wb(1'b0, mpp_pkg::STAT_OFS, 32'h0, q);
        chk("status mii dte", 32'h0, q);
        wb(1'b1, 4'h8, 32'hff, q);
        wb(1'b0, 4'h8, 32'h0, q);
        chk("unmapped", 32'h0, q);
        chk("clk oe dte", 32'h0, {30'h0, rx_oe, tx_oe});
        rx_frame(3, -1, 1'b1, 1'b0);
        rx_frame(2, -1, 1'b0, 1'b0);
        rx_frame(4, 1, 1'b0, 1'b1);
        col <= 1'b1;
        tx_frame(3);
        chk("tx count", 32'h3, 32'(u_phy.tx_q.size()));
        for (int i = 0; i < 3; i++) chk("tx byte", {24'h0, 8'h3c + 8'(i * 29)}, {24'h0, u_phy.tx_q[i]});
        wb(1'b0, mpp_pkg::STAT_OFS, 32'h0, q);
        chk("col full duplex", 32'h0, q & 32'h4);
        wb(1'b1, mpp_pkg::CTRL_OFS, 32'h1, q);
        u_phy.tx_q.delete();
        tx_frame(4);
        wb(1'b0, mpp_pkg::STAT_OFS, 32'h0, q);
        chk("col half duplex", 32'h4, q & 32'h4);
        chk("tx cut", 32'h0, {31'h0, u_phy.tx_q.size() == 4});
        col <= 1'b0;
        wb(1'b1, mpp_pkg::STAT_OFS, 32'h4, q);
        wb(1'b0, mpp_pkg::STAT_OFS, 32'h0, q);
        chk("col clear", 32'h0, q & 32'h4);
        for (int i = 0; i < 9; i++) u_phy.frame_q[i] = 8'(i + 1);
        u_phy.send_frame(9, -1, 1'b0);
        wb(1'b0, mpp_pkg::STAT_OFS, 32'h0, q);
        chk("overrun", 32'h8, q & 32'h8);
        for (int i = 0; i < 8; i++)
        begin
            pop(w, got);
            chk("fifo word", 32'(i + 1), {22'h0, w});
        end
        got = 1'b1;
        while (got) pop(w, got);
        chk("fifo empty", 32'h0, {31'h0, rx_valid});
        role <= 1'b1;
        repeat (8) @(posedge clk_i);
        wb(1'b0, mpp_pkg::STAT_OFS, 32'h0, q);
        chk("status dce", 32'h2, q & 32'h3);
        for (int s = 1; s >= 0; s--)
        begin
            wb(1'b1, mpp_pkg::CTRL_OFS, 32'(2 + s), q);
            period(n);
            chk("dce period", s ? 32'h50 : 32'h320, 32'(n));
            chk("tx clk", {29'h0, rx_clk_o, 2'h3}, {29'h0, tx_clk_o, rx_oe, tx_oe});
        end
        {rst_i, rmii} <= 2'h3;
        repeat (16) @(posedge clk_i);
        rst_i <= 1'b0;
        repeat (6) @(posedge clk_i);
        wb(1'b0, mpp_pkg::STAT_OFS, 32'h0, q);
        chk("status rmii", 32'h1, q & 32'h3);
        chk("clk oe rmii", 32'h0, {30'h0, rx_oe, tx_oe});
        // Each nibble slot lands on one reference tick, so only its low dibit counts
        u_phy.frame_q[0] = 8'h36;
        u_phy.frame_q[1] = 8'h09;
        u_phy.send_frame(2, -1, 1'b0);
        pop(w, got);
        chk("rmii byte", 32'h1e, {22'h0, w});
        pop(w, got);
        chk("rmii end", 32'h200, {22'h0, w});
        end_of_test();
    end
endmodule // mpp_port_test
`default_nettype wire
